// [design/dtc_pkg.sv]
// constants of the dual timer/counter: special function addresses, field positions, resets
// assumes an 8-bit special function register port driven by the processor core
// Behaviour
// [R1] counter/timer select: mode bit 2 for timer a, bit 6 for timer b
// [R2] timer function advances once per six peripheral clocks
// [R3] counter function samples pin per machine cycle, counts high-then-low samples
// [R4] mode field: 13-bit, 16-bit, 8-bit auto-reload, timer b halted in mode 3
// [R5] timer a mode 3: low byte timer/counter, high byte separate 8-bit timer
// [R6] mode 0 counts high byte plus low five bits; upper three ignored
// [R7] mode 0 wrap from all ones to zero sets the overflow flag
// [R8] count only with run bit set and gating off or gate input high
// [R9] timer b fields in mode bits 7..4, timer a in 3..0
// [R10] overflow flags bits 7 and 5; cleared on service entry or by software
// [R11] run bits 6 and 4; clearing halts and holds the count
// [R12] mode, control and all four count bytes reset to zero
// [R13] peripheral clock is half oscillator in twelve-clock mode, full in six-clock
// [R14] mode 1 is one 16-bit counter, flag on roll from all ones
// [R15] mode 2 low byte overflow sets flag and reloads from high byte
// [R16] timer a mode 3 high byte uses timer b run bit and overflow flag
// [R17] timer a mode 3 leaves timer b counting without run bit or flag
// [R18] software write to a count byte beats a same-cycle increment
package dtc_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_A_LOW = 8'h8a;
    localparam logic [7:0] ADDR_B_LOW = 8'h8b;
    localparam logic [7:0] ADDR_A_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_B_HIGH = 8'h8d;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // control register bit positions
    localparam int CTRL_B_FLAG = 7;
    localparam int CTRL_B_RUN = 6;
    localparam int CTRL_A_FLAG = 5;
    localparam int CTRL_A_RUN = 4;
    // mode register: nibble base per timer, field offsets inside a nibble
    localparam int MODE_A_BASE = 0;
    localparam int MODE_B_BASE = 4;
    localparam int FLD_GATE = 3;
    localparam int FLD_COUNTER = 2;
    localparam int FLD_MODE_HIGH = 1;
    localparam int FLD_MODE_LOW = 0;
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [4:0] PRESCALE_MAX = 5'h1f;
    // peripheral clocks per machine cycle
    localparam int PERIPH_PER_MACHINE = 6;
    localparam logic [2:0] MACH_LAST = 3'(PERIPH_PER_MACHINE - 1);
endpackage

// [design/dtc_tick_gen.sv]
// peripheral clock enable and machine-cycle tick for the timers
// assumes clk is the oscillator; mode strap is steady during operation
module dtc_tick_gen (
    input wire logic clk,
    input wire logic rst,
    input wire logic six_clock_cycle_mode,
    output logic mach_tick
);
    logic phase;
    logic next_phase;
    logic [2:0] div;
    logic [2:0] next_div;
    logic next_mach_tick;
    logic periph_tick;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // six-clock mode: every oscillator edge is a peripheral clock
        periph_tick = six_clock_cycle_mode | phase; // [R13]
        next_phase = six_clock_cycle_mode ? 1'b0 : ~phase; // [R13]
        next_div = div;
        next_mach_tick = 1'b0;
        if (periph_tick) begin
            if (div == dtc_pkg::MACH_LAST) begin
                next_div = 3'h0;
                next_mach_tick = 1'b1; // [R2]
            end else begin
                next_div = div + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 1'b0;
            div <= 3'h0;
            mach_tick <= 1'b0;
        end else begin
            phase <= next_phase;
            div <= next_div;
            mach_tick <= next_mach_tick;
        end
    end
endmodule

// [design/dtc_top.sv]
// dual 16-bit timer/counter behind the special function register port
// assumes gate and count pins are already synchronous to clk
module dtc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic six_clock_cycle_mode,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer_a_isr_entry,
    input wire logic timer_b_isr_entry,
    input wire logic timer_a_gate_input,
    input wire logic timer_b_gate_input,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    output logic timer_a_overflow_flag,
    output logic timer_b_overflow_flag,
    output logic timer_b_overflow_pulse
);
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] a_low;
    logic [7:0] a_high;
    logic [7:0] b_low;
    logic [7:0] b_high;
    logic [7:0] next_ctrl;
    logic [7:0] next_mode;
    logic [7:0] next_a_low;
    logic [7:0] next_a_high;
    logic [7:0] next_b_low;
    logic [7:0] next_b_high;
    logic [7:0] next_rdata;
    logic next_b_pulse;
    logic mach_tick;
    logic [1:0] pin_now;
    logic [1:0] pin_sample;
    logic [1:0] pin_prev;
    logic [1:0] pin_fall;
    logic [3:0] a_cfg;
    logic [3:0] b_cfg;
    logic a_event;
    logic b_event;
    logic a_inc;
    logic b_inc;
    logic a_high_inc;
    logic a_split;
    logic a_wr_low;
    logic a_wr_high;
    logic b_wr_cnt;
    logic [16:0] a_step;
    logic [16:0] b_step;
    logic [8:0] a_high_sum;
    logic set_a;
    logic set_b;

    // one count step: returns {overflow, high, low}
    function automatic logic [16:0] dtc_step(input logic [1:0] m, input logic [7:0] lo,
                                             input logic [7:0] hi, input logic inc);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        logic [16:0] r;
        s13 = {1'b0, hi, lo[4:0]} + 14'h1;
        s16 = {1'b0, hi, lo} + 17'h1;
        s8 = {1'b0, lo} + 9'h1;
        r = {1'b0, hi, lo};
        if (inc) begin
            case (m)
                dtc_pkg::MODE_13BIT: begin
                    // upper three low bits keep their value
                    r = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // [R6] [R7]
                end
                dtc_pkg::MODE_16BIT: begin
                    r = s16; // [R14]
                end
                dtc_pkg::MODE_RELOAD: begin
                    r = {s8[8], hi, (s8[8] ? hi : s8[7:0])}; // [R15]
                end
                dtc_pkg::MODE_SPLIT: begin
                    // only timer a reaches here with inc set
                    r = {s8[8], hi, s8[7:0]}; // [R5]
                end
                default: begin
                    r = {1'b0, hi, lo};
                end
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    dtc_tick_gen u_tick (
        .clk(clk),
        .rst(rst),
        .six_clock_cycle_mode(six_clock_cycle_mode),
        .mach_tick(mach_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // count pin sampling, one sampler per timer
    assign pin_now = {timer_b_count_pin, timer_a_count_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic next_sample;
            logic next_prev;
            always_comb begin
                next_sample = pin_sample[gi];
                next_prev = pin_prev[gi];
                if (mach_tick) begin
                    next_sample = pin_now[gi]; // [R3]
                    next_prev = pin_sample[gi];
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pin_sample[gi] <= 1'b0;
                    pin_prev[gi] <= 1'b0;
                end else begin
                    pin_sample[gi] <= next_sample;
                    pin_prev[gi] <= next_prev;
                end
            end
            // one count per machine cycle, at the tick after a high-then-low pair
            assign pin_fall[gi] = mach_tick & pin_prev[gi] & ~pin_sample[gi]; // [R3]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // counting and register writes
    always_comb begin
        a_cfg = mode[dtc_pkg::MODE_A_BASE +: 4]; // [R9]
        b_cfg = mode[dtc_pkg::MODE_B_BASE +: 4]; // [R9]
        a_split = a_cfg[dtc_pkg::FLD_MODE_HIGH:dtc_pkg::FLD_MODE_LOW] == dtc_pkg::MODE_SPLIT;
        // a count byte write drops the whole step, carry and flag included
        a_wr_low = sfr_wr & (sfr_addr == dtc_pkg::ADDR_A_LOW);
        a_wr_high = sfr_wr & (sfr_addr == dtc_pkg::ADDR_A_HIGH);
        b_wr_cnt = sfr_wr & ((sfr_addr == dtc_pkg::ADDR_B_LOW)
            | (sfr_addr == dtc_pkg::ADDR_B_HIGH));
        a_event = a_cfg[dtc_pkg::FLD_COUNTER] ? pin_fall[0] : mach_tick; // [R1] [R2]
        b_event = b_cfg[dtc_pkg::FLD_COUNTER] ? pin_fall[1] : mach_tick; // [R1] [R2]
        a_inc = ctrl[dtc_pkg::CTRL_A_RUN] & a_event
            & (~a_cfg[dtc_pkg::FLD_GATE] | timer_a_gate_input) // [R8] [R11]
            & ~(a_wr_low | (a_wr_high & ~a_split)); // [R18]
        // timer b gives up its run bit while timer a is split
        b_inc = (a_split | ctrl[dtc_pkg::CTRL_B_RUN]) & b_event
            & (~b_cfg[dtc_pkg::FLD_GATE] | timer_b_gate_input)
            & (b_cfg[dtc_pkg::FLD_MODE_HIGH:dtc_pkg::FLD_MODE_LOW]
               != dtc_pkg::MODE_SPLIT) & ~b_wr_cnt; // [R4] [R8] [R11] [R17] [R18]
        a_high_inc = a_split & ctrl[dtc_pkg::CTRL_B_RUN] & mach_tick & ~a_wr_high; // [R16] [R18]
        a_step = dtc_step(a_cfg[1:0], a_low, a_high, a_inc); // [R4]
        b_step = dtc_step(b_cfg[1:0], b_low, b_high, b_inc); // [R4]
        a_high_sum = {1'b0, a_high} + 9'h1;
        set_a = a_step[16]; // [R7] [R10]
        set_b = a_split ? (a_high_inc & a_high_sum[8]) : b_step[16]; // [R16] [R17]

        next_mode = mode;
        next_a_low = a_step[7:0];
        next_a_high = a_split ? (a_high_inc ? a_high_sum[7:0] : a_high) : a_step[15:8]; // [R5]
        next_b_low = b_step[7:0];
        next_b_high = b_step[15:8];
        next_ctrl = ctrl;
        if (timer_a_isr_entry) begin
            next_ctrl[dtc_pkg::CTRL_A_FLAG] = 1'b0; // [R10]
        end
        if (timer_b_isr_entry) begin
            next_ctrl[dtc_pkg::CTRL_B_FLAG] = 1'b0; // [R10]
        end
        if (sfr_wr) begin
            case (sfr_addr)
                // low nibble belongs to the external interrupt logic, not kept here
                dtc_pkg::ADDR_CTRL: next_ctrl = {sfr_wdata[7:4], 4'h0}; // [R10] [R11]
                dtc_pkg::ADDR_MODE: next_mode = sfr_wdata;
                dtc_pkg::ADDR_A_LOW: next_a_low = sfr_wdata; // [R18]
                dtc_pkg::ADDR_B_LOW: next_b_low = sfr_wdata; // [R18]
                dtc_pkg::ADDR_A_HIGH: next_a_high = sfr_wdata; // [R18]
                dtc_pkg::ADDR_B_HIGH: next_b_high = sfr_wdata; // [R18]
                default: next_mode = mode;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        if (set_a) begin
            next_ctrl[dtc_pkg::CTRL_A_FLAG] = 1'b1; // [R10]
        end
        if (set_b) begin
            next_ctrl[dtc_pkg::CTRL_B_FLAG] = 1'b1; // [R10]
        end
        // baud source sees timer b roll even when its flag is taken over
        next_b_pulse = b_step[16];

        case (sfr_addr)
            dtc_pkg::ADDR_CTRL: next_rdata = ctrl;
            dtc_pkg::ADDR_MODE: next_rdata = mode;
            dtc_pkg::ADDR_A_LOW: next_rdata = a_low;
            dtc_pkg::ADDR_B_LOW: next_rdata = b_low;
            dtc_pkg::ADDR_A_HIGH: next_rdata = a_high;
            dtc_pkg::ADDR_B_HIGH: next_rdata = b_high;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= dtc_pkg::RESET_BYTE; // [R12]
            mode <= dtc_pkg::RESET_BYTE; // [R12]
            a_low <= dtc_pkg::RESET_BYTE; // [R12]
            a_high <= dtc_pkg::RESET_BYTE; // [R12]
            b_low <= dtc_pkg::RESET_BYTE; // [R12]
            b_high <= dtc_pkg::RESET_BYTE; // [R12]
            sfr_rdata <= 8'h00;
            timer_b_overflow_pulse <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            a_low <= next_a_low;
            a_high <= next_a_high;
            b_low <= next_b_low;
            b_high <= next_b_high;
            sfr_rdata <= next_rdata;
            timer_b_overflow_pulse <= next_b_pulse;
        end
    end

    assign timer_a_overflow_flag = ctrl[dtc_pkg::CTRL_A_FLAG];
    assign timer_b_overflow_flag = ctrl[dtc_pkg::CTRL_B_FLAG];
endmodule

// [sim/dtc_top_bench.sv]
// self-checking bench for the dual timer/counter
// assumes dtc_top with one clock; inputs driven on the falling edge
module dtc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dtc_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic six = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic isr_a = 1'b0;
    logic isr_b = 1'b0;
    logic gate_a = 1'b0;
    logic gate_b = 1'b0;
    logic cnt_a = 1'b0;
    logic flag_a, flag_b, pulse;
    int pulse_count = 0;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // rows write with all timers stopped so nothing counts under them
    dtc_row_t rows [8] = '{'{8'h89, 8'ha5, 8'ha5}, '{8'h8a, 8'h3c, 8'h3c},
        '{8'h8b, 8'hc3, 8'hc3}, '{8'h8c, 8'h5a, 8'h5a}, '{8'h8d, 8'h96, 8'h96},
        '{8'h88, 8'haf, 8'ha0}, '{8'h8e, 8'hff, 8'h00}, '{8'h89, 8'h00, 8'h00}};
    dtc_top dtc_top_i (.clk(clk), .rst(rst), .six_clock_cycle_mode(six), .sfr_addr(addr),
        .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rdata(rdata), .timer_a_isr_entry(isr_a),
        .timer_b_isr_entry(isr_b), .timer_a_gate_input(gate_a), .timer_b_gate_input(gate_b),
        .timer_a_count_pin(cnt_a), .timer_b_count_pin(1'b0),
        .timer_a_overflow_flag(flag_a), .timer_b_overflow_flag(flag_b),
        .timer_b_overflow_pulse(pulse));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pulse) begin
            pulse_count <= pulse_count + 1;
        end
        if (cycles == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic mode);
        rst = 1'b1;
        six = mode;
        repeat (10) @(negedge clk);
        rst = 1'b0;
    endtask
    // a gap cycle after each write keeps the strobe from being driven twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        cmp_byte(rdata, e);
    endtask
    task automatic wait_flag(input bit b);
        int n;
        n = 0;
        while ((b ? flag_b : flag_a) !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp_bit(b ? flag_b : flag_a, 1'b1);
    endtask
    task automatic isr_pulse(input bit b);
        @(negedge clk);
        {isr_b, isr_a} = b ? 2'h2 : 2'h1;
        @(negedge clk);
        {isr_b, isr_a} = 2'h0;
        cmp_bit(b ? flag_b : flag_a, 1'b0);
    endtask
    // returns at the second falling edge after the roll that made the pulse
    task automatic wait_pulses(input int k);
        int n;
        n = 0;
        while (pulse_count < k && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp_byte(8'(pulse_count), 8'(k));
    endtask
    // run enabled for exactly 120 clock edges, then held
    task automatic run_window(input logic [7:0] exp);
        wr_reg(8'h89, 8'h01);
        wr_reg(8'h88, 8'h10);
        repeat (118) @(negedge clk);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, exp);
        repeat (30) @(negedge clk);
        rd_chk(8'h8a, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b1);
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(8'h88 + i), 8'h00);
        end
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        do_reset(1'b1);
        run_window(8'h14);
        wr_reg(8'h8a, 8'hff);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h88, 8'h10);
        wait_flag(1'b0);
        isr_pulse(1'b0);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, 8'h00);
        wr_reg(8'h89, 8'h00);
        wr_reg(8'h8a, 8'hff);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h88, 8'h10);
        wait_flag(1'b0);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, 8'he0);
        rd_chk(8'h8c, 8'h00);
        wr_reg(8'h89, 8'h20);
        wr_reg(8'h8d, 8'ha5);
        wr_reg(8'h8b, 8'hff);
        wr_reg(8'h88, 8'h40);
        wait_flag(1'b1);
        isr_pulse(1'b1);
        cmp_byte(8'(pulse_count), 8'h01);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8b, 8'ha5);
        rd_chk(8'h8d, 8'ha5);
        // gated: held while the gate input is low, counts once it is high
        wr_reg(8'h89, 8'h09);
        wr_reg(8'h8a, 8'h00);
        wr_reg(8'h88, 8'h10);
        repeat (60) @(negedge clk);
        rd_chk(8'h8a, 8'h00);
        gate_a = 1'b1;
        repeat (118) @(negedge clk);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, 8'h14);
        wr_reg(8'h89, 8'h05);
        wr_reg(8'h8a, 8'h00);
        wr_reg(8'h88, 8'h10);
        repeat (3) begin
            cnt_a = 1'b1;
            repeat (12) @(negedge clk);
            cnt_a = 1'b0;
            repeat (12) @(negedge clk);
        end
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, 8'h03);
        wr_reg(8'h89, 8'h33);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h88, 8'h40);
        wait_flag(1'b1);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8c, 8'h00);
        rd_chk(8'h8b, 8'ha5);
        // timer a split: gated timer b counts without its run bit, sets no flag
        wr_reg(8'h8b, 8'hff);
        wr_reg(8'h89, 8'ha3);
        repeat (14) @(negedge clk);
        rd_chk(8'h8b, 8'hff);
        gate_b = 1'b1;
        wait_pulses(2);
        cmp_bit(flag_b, 1'b0);
        // next tick is six clocks after the roll: this write lands on it
        repeat (3) @(negedge clk);
        wr_reg(8'h8b, 8'h10);
        wr_reg(8'h89, 8'h33);
        rd_chk(8'h8b, 8'h10);
        do_reset(1'b0);
        run_window(8'h0a);
        complete_run();
    end
endmodule

// [sim/dtc_top_chk.sv]
// checker for the dual timer/counter register port and flags
// assumes it is bound onto dtc_top and sees only its ports
module dtc_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic six_clock_cycle_mode,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer_a_isr_entry,
    input wire logic timer_b_isr_entry,
    input wire logic timer_a_gate_input,
    input wire logic timer_b_gate_input,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    input wire logic timer_a_overflow_flag,
    input wire logic timer_b_overflow_flag,
    input wire logic timer_b_overflow_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ctrl_low_zero:
        assert property ($past(sfr_addr) == 8'h88 |-> sfr_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    chk_flag_a_read:
        assert property ($past(sfr_addr) == 8'h88 |-> sfr_rdata[5] == $past(timer_a_overflow_flag))
        else $error("flag a read mismatch");
    chk_flag_b_read:
        assert property ($past(sfr_addr) == 8'h88 |-> sfr_rdata[7] == $past(timer_b_overflow_flag))
        else $error("flag b read mismatch");
    chk_mode_readback:
        assert property (sfr_wr && sfr_addr == 8'h89 ##1 sfr_addr == 8'h89 && !sfr_wr
            |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("mode read back wrong");
    chk_run_readback:
        assert property (sfr_wr && sfr_addr == 8'h88 ##1 sfr_addr == 8'h88 && !sfr_wr
            |=> (sfr_rdata & 8'h50) == ($past(sfr_wdata, 2) & 8'h50))
        else $error("run bits read back wrong");
    chk_flag_a_write:
        assert property (sfr_wr && sfr_addr == 8'h88 && sfr_wdata[5] && !timer_a_isr_entry
            |=> timer_a_overflow_flag)
        else $error("software set of flag a lost");
    chk_pulse_single:
        assert property (timer_b_overflow_pulse |=> !timer_b_overflow_pulse [*5])
        else $error("overflow pulses closer than a machine cycle");
    chk_reset_clear:
        assert property ($fell(rst) |-> sfr_rdata == 8'h00 && !timer_a_overflow_flag
            && !timer_b_overflow_flag)
        else $error("state not cleared by reset");
    cover property (timer_b_overflow_pulse);
    cover property ($rose(timer_a_overflow_flag));
    cover property ($rose(timer_b_overflow_flag));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dtc_top dtc_top_chk dtc_top_chk_i (.clk(clk), .rst(rst),
    .six_clock_cycle_mode(six_clock_cycle_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_a_isr_entry(timer_a_isr_entry),
    .timer_b_isr_entry(timer_b_isr_entry), .timer_a_gate_input(timer_a_gate_input),
    .timer_b_gate_input(timer_b_gate_input), .timer_a_count_pin(timer_a_count_pin),
    .timer_b_count_pin(timer_b_count_pin), .timer_a_overflow_flag(timer_a_overflow_flag),
    .timer_b_overflow_flag(timer_b_overflow_flag),
    .timer_b_overflow_pulse(timer_b_overflow_pulse));
